// *** hw/fsc_status_regs.sv ***
// status and configuration register logic of a serial flash
`timescale 1ns/1ps
module fsc_status_regs #(
   parameter logic [15:0] TW_CYCLES = 16'(fsc_pkg::TW_CYC)
) (
   // system clock and reset
   input  wire logic       clock,
   input  wire logic       reset_n,
   // serial link pins
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       si_in,
   input  wire logic       wp_n_in,
   output logic            so_out,
   output logic            so_oe,
   // program and erase engine
   input  wire logic       target_protected,
   input  wire logic       pe_done,
   output logic            pe_start,
   output logic [7:0]      pe_cmd,
   // register state for the rest of the device
   output fsc_pkg::fsc_status_t status_byte,
   output fsc_pkg::fsc_config_t configuration_byte,
   output logic            hw_protect_mode,
   output logic [3:0]      dual_dummy,
   output logic [3:0]      quad_dummy
);
   import fsc_pkg::*;

   // ****************************************
   // decode helpers
   // ****************************************
   // opcodes that change the array
   function automatic logic is_pe(input logic [7:0] op);
      is_pe = (op == CMD_PAGE_PROGRAM) || (op == CMD_QUAD_PROGRAM) ||
              (op == CMD_SECTOR_ERASE) || (op == CMD_HALF_BLOCK_ERASE) ||
              (op == CMD_BLOCK_ERASE) || is_chip(op);
   endfunction

   // whole array erase codes
   function automatic logic is_chip(input logic [7:0] op);
      is_chip = (op == CMD_CHIP_ERASE) || (op == CMD_CHIP_ERASE_ALT);
   endfunction

   // ****************************************
   // declarations
   // ****************************************
   fsc_frame_t  frame_r;       // link side frame capture
   logic        first_r;       // next link edge is a frame's first
   logic [15:0] snap;          // register bytes seen by the link side
   logic        tx_active;     // frame is a register read past its opcode
   logic [1:0]  pins_s;        // synced chip select and write protect
   logic        cs_d_r;        // previous synced chip select
   logic        frame_end;     // chip select has just risen
   logic        busy_now;      // any write cycle running
   logic        write_enable_cmd_go;       // write enable taken
   logic        wrdi_go;       // write disable taken
   logic        write_status_cmd_go;       // status write started
   logic        pe_req;        // program or erase with latch set
   logic        pe_block;      // ... but refused by protection
   logic        pe_go;         // ... and handed to the engine
   logic        wip_done;      // last cycle of the status write
   logic [15:0] wip_cnt_r;     // status write timer
   logic [15:0] wr_data_r;     // bytes waiting for the write to end
   logic        wr_long_r;     // config byte was sent too
   logic        pe_active_r;   // engine busy
   logic        wel_r;         // write latch
   logic        busy_r;        // busy flag as read back
   logic        lock_r;        // status lock
   logic        quad_r;        // quad enable
   logic [3:0]  level_r;       // protect level
   logic        bottom_r;      // protect from bottom
   logic        dummy_r;       // dummy select
   logic        hpm_r;         // hardware protection active
   logic        pe_start_r;    // engine start pulse
   logic [7:0]  pe_cmd_r;      // engine opcode
   logic [7:0]  new_status;    // status byte to apply
   logic [7:0]  new_config;    // config byte to apply
   logic [3:0]  dual_dummy_r;  // dual read latency
   logic [3:0]  quad_dummy_r;  // quad read latency

   // ****************************************
   // link domain: frame capture
   // ****************************************
   // marks the first edge; chip select high rearms it
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   // opcode, data and edge count; held after the frame for the system side
   always_ff @(posedge sclk or negedge reset_n) begin
      if (!reset_n) begin
         frame_r <= '0;
      end else if (first_r) begin
         frame_r.opcode <= {7'h00, si_in};
         frame_r.data   <= 16'h0000;
         frame_r.bits   <= 5'h01;
      end else begin
         if (frame_r.bits < OPCODE_BITS) begin
            frame_r.opcode <= {frame_r.opcode[6:0], si_in};
         end else if (frame_r.bits < WRITE_STATUS_CMD_LONG_BITS) begin
            frame_r.data <= {frame_r.data[14:0], si_in};
         end
         if (frame_r.bits != BITS_MAX) begin
            frame_r.bits <= frame_r.bits + 5'h01;
         end
      end
   end

   // ****************************************
   // link domain: register read out
   // ****************************************
   // register bytes cross on link clock edges only, two edges late, busy included
   fsc_sync #(.W(16), .INIT(16'h0000)) u_snap_sync (
      .clk   (sclk),
      .rst_n (reset_n),
      .d     ({status_byte, configuration_byte}),
      .q     (snap)
   );

   // only the output line is driven, the upper lines stay untouched
   assign tx_active = (frame_r.bits >= OPCODE_BITS) &&
                      ((frame_r.opcode == CMD_READ_STATUS) ||
                       (frame_r.opcode == CMD_READ_CONFIG));

   fsc_status_tx u_tx (
      .sclk    (sclk),
      .cs_n    (cs_n),
      .active  (tx_active),
      .byte_in ((frame_r.opcode == CMD_READ_CONFIG) ? snap[7:0] : snap[15:8]),
      .so      (so_out),
      .oe      (so_oe)
   );

   // ****************************************
   // system domain: frame end and decode
   // ****************************************
   // chip select and write protect pins, idle high
   fsc_sync #(.W(2), .INIT(2'h3)) u_pin_sync (
      .clk   (clock),
      .rst_n (reset_n),
      .d     ({cs_n, wp_n_in}),
      .q     (pins_s)
   );

   // rising chip select closes a frame
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         cs_d_r <= 1'b1;
      end else begin
         cs_d_r <= pins_s[1];
      end
   end

   assign frame_end = pins_s[1] && !cs_d_r;
   assign busy_now  = (wip_cnt_r != 16'h0000) || pe_active_r;
   // frame_r is static while chip select is high, so it is read directly
   assign write_enable_cmd_go   = frame_end && !busy_now && (frame_r.bits == OPCODE_BITS) &&
                      (frame_r.opcode == CMD_WRITE_ENABLE);
   assign wrdi_go   = frame_end && !busy_now && (frame_r.bits == OPCODE_BITS) &&
                      (frame_r.opcode == CMD_WRITE_DISABLE);
   assign write_status_cmd_go   = frame_end && !busy_now && wel_r && !hpm_r &&
                      (frame_r.opcode == CMD_WRITE_STATUS) &&
                      ((frame_r.bits == WRITE_STATUS_CMD_SHORT_BITS) ||
                       (frame_r.bits == WRITE_STATUS_CMD_LONG_BITS));
   assign pe_req    = frame_end && !busy_now && wel_r && is_pe(frame_r.opcode);
   assign pe_block  = pe_req && (target_protected ||
                      (is_chip(frame_r.opcode) && (level_r != 4'h0)));
   assign pe_go     = pe_req && !pe_block;
   assign wip_done  = (wip_cnt_r == 16'h0001);

   // ****************************************
   // write latch
   // ****************************************
   // setting wins; completions only occur while busy, when no set is taken
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wel_r <= STATUS_RESET.latch;
      end else if (write_enable_cmd_go) begin
         wel_r <= 1'b1;
      end else if (wrdi_go || pe_block) begin
         wel_r <= 1'b0;
      end else if (wip_done || (pe_active_r && pe_done)) begin
         wel_r <= 1'b0;
      end
   end

   // ****************************************
   // self-timed status write
   // ****************************************
   // timer and the bytes held until it expires
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wip_cnt_r <= 16'h0000;
         wr_data_r <= 16'h0000;
         wr_long_r <= 1'b0;
      end else if (write_status_cmd_go) begin
         wip_cnt_r <= TW_CYCLES;
         wr_data_r <= frame_r.data;
         wr_long_r <= (frame_r.bits == WRITE_STATUS_CMD_LONG_BITS);
      end else if (wip_cnt_r != 16'h0000) begin
         wip_cnt_r <= wip_cnt_r - 16'h0001;
      end
   end

   // status byte first, config byte second when sent
   assign new_status = wr_long_r ? wr_data_r[15:8] : wr_data_r[7:0];
   assign new_config = wr_data_r[7:0];

   // non-volatile bits change only here, at the end of a status write
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         lock_r   <= STATUS_RESET.lock;
         quad_r   <= STATUS_RESET.quad;
         level_r  <= STATUS_RESET.level;
         bottom_r <= CONFIG_RESET.bottom;
         dummy_r  <= CONFIG_RESET.dummy;
      end else if (wip_done) begin
         lock_r  <= new_status[7];
         quad_r  <= new_status[6];
         level_r <= new_status[5:2];
         if (wr_long_r) begin
            bottom_r <= bottom_r | new_config[3];
            dummy_r  <= new_config[6];
         end
      end
   end

   // ****************************************
   // program and erase hand-off
   // ****************************************
   // start pulse, opcode and engine busy
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pe_start_r  <= 1'b0;
         pe_cmd_r    <= 8'h00;
         pe_active_r <= 1'b0;
      end else begin
         pe_start_r <= pe_go;
         if (pe_go) begin
            pe_cmd_r    <= frame_r.opcode;
            pe_active_r <= 1'b1;
         end else if (pe_done) begin
            pe_active_r <= 1'b0;
         end
      end
   end

   // ****************************************
   // derived state
   // ****************************************
   // busy flag, protection mode and read latency
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         busy_r       <= STATUS_RESET.busy;
         hpm_r        <= 1'b0;
         dual_dummy_r <= DUAL_DUMMY_LO;
         quad_dummy_r <= QUAD_DUMMY_LO;
      end else begin
         busy_r       <= busy_now;
         hpm_r        <= lock_r && !pins_s[0] && !quad_r;
         dual_dummy_r <= dummy_r ? DUAL_DUMMY_HI : DUAL_DUMMY_LO;
         quad_dummy_r <= dummy_r ? QUAD_DUMMY_HI : QUAD_DUMMY_LO;
      end
   end

   // register bytes as read back
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_byte        <= STATUS_RESET;
         configuration_byte <= CONFIG_RESET;
      end else begin
         status_byte        <= {lock_r, quad_r, level_r, wel_r, busy_r};
         configuration_byte <= {1'b0, dummy_r, 2'h0, bottom_r, 3'h0};
      end
   end

   assign pe_start        = pe_start_r;
   assign pe_cmd          = pe_cmd_r;
   assign hw_protect_mode = hpm_r;
   assign dual_dummy      = dual_dummy_r;
   assign quad_dummy      = quad_dummy_r;

   // ****************************************
   // assertions
   // ****************************************
   busy_flag_a: assert property (@(posedge clock) disable iff (!reset_n)
      pe_go |=> ##2 status_byte.busy) else $error("busy not shown after start");
   latch_set_a: assert property (@(posedge clock) disable iff (!reset_n)
      write_enable_cmd_go |=> wel_r ##1 status_byte.latch) else $error("latch not set");
   pe_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
      pe_start_r |-> $past(wel_r)) else $error("engine started without latch");
   pe_clear_a: assert property (@(posedge clock) disable iff (!reset_n)
      pe_active_r && pe_done |=> !wel_r) else $error("latch kept after completion");
   prot_block_a: assert property (@(posedge clock) disable iff (!reset_n)
      pe_block |=> !wel_r && !pe_start_r && !pe_active_r) else $error("protected op run");
   level_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
      !wip_done |=> $stable(level_r)) else $error("level changed outside write");
   chip_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
      pe_start_r && is_chip(pe_cmd_r) |-> $past(level_r) == 4'h0)
      else $error("chip erase with level set");
   hpm_reject_a: assert property (@(posedge clock) disable iff (!reset_n)
      frame_end && hpm_r && !busy_now |=> wip_cnt_r == 16'h0000)
      else $error("status write taken in hardware protection");
   bottom_otp_a: assert property (@(posedge clock) disable iff (!reset_n)
      bottom_r |=> bottom_r) else $error("bottom bit cleared");
   dummy_sel_a: assert property (@(posedge clock) disable iff (!reset_n)
      1'b1 |=> dual_dummy_r == ($past(dummy_r) ? DUAL_DUMMY_HI : DUAL_DUMMY_LO) &&
               quad_dummy_r == ($past(dummy_r) ? QUAD_DUMMY_HI : QUAD_DUMMY_LO))
      else $error("latency does not follow select");
   write_status_cmd_len_a: assert property (@(posedge clock) disable iff (!reset_n)
      frame_end && !busy_now && (frame_r.bits != WRITE_STATUS_CMD_SHORT_BITS) &&
      (frame_r.bits != WRITE_STATUS_CMD_LONG_BITS) |=> wip_cnt_r == 16'h0000)
      else $error("status write of wrong length taken");
   write_status_cmd_cycle_a: assert property (@(posedge clock) disable iff (!reset_n)
      write_status_cmd_go |=> busy_now [*8]) else $error("busy dropped early");
   write_status_cmd_end_a: assert property (@(posedge clock) disable iff (!reset_n)
      wip_done |=> !wel_r ##1 !busy_r) else $error("write end not seen");

endmodule

// *** hw/fsc_pkg.sv ***
// package: opcodes, field layouts, reset values and timing of the status/config block
package fsc_pkg;

   // ****************************************
   // command opcodes
   // ****************************************
   localparam logic [7:0] CMD_WRITE_ENABLE     = 8'h06;  // sets the write latch
   localparam logic [7:0] CMD_WRITE_DISABLE    = 8'h04;  // clears the write latch
   localparam logic [7:0] CMD_READ_STATUS      = 8'h05;  // status byte out
   localparam logic [7:0] CMD_READ_CONFIG      = 8'h15;  // configuration byte out
   localparam logic [7:0] CMD_WRITE_STATUS     = 8'h01;  // status and config write
   localparam logic [7:0] CMD_PAGE_PROGRAM     = 8'h02;  // single line program
   localparam logic [7:0] CMD_QUAD_PROGRAM     = 8'h38;  // four line program
   localparam logic [7:0] CMD_SECTOR_ERASE     = 8'h20;  // smallest erase
   localparam logic [7:0] CMD_HALF_BLOCK_ERASE = 8'h52;  // half block erase
   localparam logic [7:0] CMD_BLOCK_ERASE      = 8'hD8;  // full block erase
   localparam logic [7:0] CMD_CHIP_ERASE       = 8'h60;  // whole array erase
   localparam logic [7:0] CMD_CHIP_ERASE_ALT   = 8'hC7;  // second code for it

   // ****************************************
   // frame lengths, in link clock edges
   // ****************************************
   localparam logic [4:0] OPCODE_BITS     = 5'h08;  // opcode length
   localparam logic [4:0] WRITE_STATUS_CMD_SHORT_BITS = 5'h10;  // opcode plus status byte
   localparam logic [4:0] WRITE_STATUS_CMD_LONG_BITS  = 5'h18;  // opcode plus both bytes
   localparam logic [4:0] BITS_MAX        = 5'h1F;  // edge counter saturates here

   // ****************************************
   // read latency selected by the dummy bit
   // ****************************************
   localparam logic [3:0] DUAL_DUMMY_LO = 4'h4;  // dual read, select 0
   localparam logic [3:0] DUAL_DUMMY_HI = 4'h8;  // dual read, select 1
   localparam logic [3:0] QUAD_DUMMY_LO = 4'h6;  // quad read, select 0
   localparam logic [3:0] QUAD_DUMMY_HI = 4'hA;  // quad read, select 1

   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ = 40;                 // system clock rate
   localparam int TW_US   = 40;                 // self-timed write time, plain default
   localparam int TW_CYC  = TW_US * CLK_MHZ;    // write time in clock cycles

   // ****************************************
   // carrier types and reset values
   // ****************************************
   typedef struct packed {
      logic       lock;     // bit7 status lock
      logic       quad;     // bit6 quad enable
      logic [3:0] level;    // bit5..bit2 protect level
      logic       latch;    // bit1 write latch
      logic       busy;     // bit0 busy flag
   } fsc_status_t;

   typedef struct packed {
      logic       rsv7;     // reserved, reads 0
      logic       dummy;    // bit6 dummy select
      logic [1:0] rsv5;     // reserved, reads 0
      logic       bottom;   // bit3 protect from bottom
      logic [2:0] rsv2;     // reserved, reads 0
   } fsc_config_t;

   typedef struct packed {
      logic [7:0]  opcode;  // first eight bits of the frame
      logic [15:0] data;    // up to two data bytes after it
      logic [4:0]  bits;    // edges seen, saturating
   } fsc_frame_t;

   localparam fsc_status_t STATUS_RESET = 8'h00;  // all protection off, idle
   localparam fsc_config_t CONFIG_RESET = 8'h00;  // top protect, short latency

endpackage

// *** hw/fsc_sync.sv ***
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module fsc_sync #(
   parameter int         W    = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // destination clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels in and out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;  // first stage, read only by the second

   // ****************************************
   // two stage capture
   // ****************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= INIT;
         q      <= INIT;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

// *** hw/fsc_status_tx.sv ***
// serial transmitter for a register byte on the falling link clock edge
`timescale 1ns/1ps
module fsc_status_tx (
   // link clock and frame select
   input  wire logic       sclk,
   input  wire logic       cs_n,
   // byte to send
   input  wire logic       active,
   input  wire logic [7:0] byte_in,
   // data line
   output logic            so,
   output logic            oe
);

   logic [2:0] idx_r;  // bit being sent, msb first

   // ****************************************
   // shift out, wrap to repeat the byte
   // ****************************************
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         idx_r <= 3'h7;
         so    <= 1'b0;
         oe    <= 1'b0;
      end else if (active) begin
         so    <= byte_in[idx_r];
         oe    <= 1'b1;
         idx_r <= idx_r - 3'h1;
      end
   end

endmodule

// *** tb/fsc_host.sv ***
// host serial controller model driving link frames
`timescale 1ns/1ps
module fsc_host (
   // link pins
   output logic      sclk,
   output logic      cs_n,
   output logic      si,
   input  wire logic so
);
   // idle: clock parked low, select high
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end
   // n bits of d, msb first; rx gathers so after the opcode
   task automatic xfer(input logic [23:0] d, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         si = d[23-i];  // opcode first
         #16 sclk = 1'b1;
         if (i >= 8) rx = {rx[14:0], so};
         #16 sclk = 1'b0;
      end
      #16 cs_n = 1'b1;  // only on a bit boundary
      si = ~si;  // released line shows no stale value
      #200;
   endtask
endmodule

// *** tb/tb.sv ***
// bench for the status and configuration register block
`timescale 1ns/1ps
module tb;
   import fsc_pkg::*;
   logic        clock, reset_n, wp_n_in, target_protected, pe_done;
   logic        sclk, cs_n, si_in, so_out, so_oe, pe_start, hw_protect_mode;
   logic [7:0]  pe_cmd;
   logic [3:0]  dual_dummy, quad_dummy;
   logic [15:0] rx;
   fsc_status_t status_byte;
   fsc_config_t configuration_byte;
   int          n_fail, total_checks;
   int          n_start = 0;
   // short write time keeps the run brief
   fsc_status_regs #(.TW_CYCLES(16'h0028)) u_dut (.clock(clock), .reset_n(reset_n),
      .sclk(sclk), .cs_n(cs_n), .si_in(si_in), .wp_n_in(wp_n_in), .so_out(so_out),
      .so_oe(so_oe), .target_protected(target_protected), .pe_done(pe_done),
      .pe_start(pe_start), .pe_cmd(pe_cmd), .status_byte(status_byte),
      .configuration_byte(configuration_byte), .hw_protect_mode(hw_protect_mode),
      .dual_dummy(dual_dummy), .quad_dummy(quad_dummy));
   fsc_host u_host (.sclk(sclk), .cs_n(cs_n), .si(si_in), .so(so_out));
   always #12.5 clock = ~clock;
   // counts engine starts
   always @(negedge clock) if (pe_start === 1'b1) n_start++;
   task automatic report_and_stop;
      if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // bounded wait until not busy
   task automatic settle;
      repeat (8) @(negedge clock);
      for (int k = 0; status_byte.busy !== 1'b0; k++) begin
         if (k > 300) begin
            n_fail++;
            report_and_stop();
         end
         @(negedge clock);
      end
   endtask
   task automatic cmd(input logic [7:0] op);
      u_host.xfer({op, 16'h0000}, 8, rx);
   endtask
   task automatic wr(input logic [7:0] s, input logic [7:0] c, input int n);
      cmd(CMD_WRITE_ENABLE);
      u_host.xfer({CMD_WRITE_STATUS, s, c}, n, rx);
      settle();
   endtask
   task automatic t_reset;
      chk("status", 8'h00, status_byte);  // level lock
      chk("config", 8'h00, configuration_byte);  // bottom
      chk("dual", 8'h04, {4'h0, dual_dummy});  // dual
      chk("quad", 8'h06, {4'h0, quad_dummy});  // quad
   endtask
   task automatic t_write;
      cmd(CMD_WRITE_ENABLE);
      settle();
      u_host.xfer({CMD_READ_STATUS, 16'h0000}, 24, rx);
      chk("rd_wel", 8'h02, rx[15:8]);  // latch out
      chk("rd_rep", 8'h02, rx[7:0]);  // repeat
      chk("oe_off", 8'h00, {7'h00, so_oe});  // released
      u_host.xfer({CMD_WRITE_STATUS, 16'h3C48}, 24, rx);
      chk("busy", 8'h01, {7'h00, status_byte.busy});  // busy
      u_host.xfer({CMD_READ_STATUS, 16'h0000}, 24, rx);
      chk("rd_busy", 8'h03, rx[15:8]);  // read while busy
      settle();
      chk("status", 8'h3C, status_byte);  // level done
      chk("config", 8'h48, configuration_byte);  // bottom
      u_host.xfer({CMD_READ_CONFIG, 16'h0000}, 16, rx);
      chk("rd_cfg", 8'h48, rx[7:0]);  // config out
      chk("dual", 8'h08, {4'h0, dual_dummy});  // long
      chk("quad", 8'h0A, {4'h0, quad_dummy});  // long
   endtask
   task automatic t_badlen;
      wr(8'h00, 8'h00, 20);
      chk("bad_len", 8'h3C, status_byte & 8'hFC);  // kept
   endtask
   task automatic t_refuse;
      int n0;
      n0 = n_start;
      cmd(CMD_WRITE_DISABLE);
      cmd(CMD_PAGE_PROGRAM);
      settle();
      chk("no_wel", 8'(n0), 8'(n_start));  // ignored
      target_protected = 1'b1;
      cmd(CMD_WRITE_ENABLE);
      cmd(CMD_PAGE_PROGRAM);
      settle();
      target_protected = 1'b0;
      chk("prot", 8'(n0), 8'(n_start));  // refused
      chk("prot_wel", 8'h00, {7'h00, status_byte.latch});  // cleared
      cmd(CMD_WRITE_ENABLE);
      cmd(CMD_CHIP_ERASE);
      settle();
      chk("chip", 8'(n0), 8'(n_start));  // level set
      chk("chip_wel", 8'h00, {7'h00, status_byte.latch});  // cleared
   endtask
   task automatic t_program;
      int n0;
      n0 = n_start;
      wr(8'h00, 8'h00, 24);
      chk("otp", 8'h08, configuration_byte);  // bottom kept
      cmd(CMD_WRITE_ENABLE);
      cmd(CMD_PAGE_PROGRAM);
      repeat (4) @(negedge clock);
      chk("start", 8'(n0 + 1), 8'(n_start));  // accepted
      chk("pe_cmd", CMD_PAGE_PROGRAM, pe_cmd);  // opcode
      chk("pe_busy", 8'h01, {7'h00, status_byte.busy});  // busy
      pe_done = 1'b1;
      @(negedge clock);
      pe_done = 1'b0;
      settle();  // busy seen low first
      chk("pe_wel", 8'h00, {7'h00, status_byte.latch});  // cleared
   endtask
   task automatic t_lock;
      wr(8'hC0, 8'h00, 16);
      wp_n_in = 1'b0;
      repeat (8) @(negedge clock);
      chk("hpm_quad", 8'h00, {7'h00, hw_protect_mode});  // quad
      wr(8'h80, 8'h00, 16);
      chk("hpm", 8'h01, {7'h00, hw_protect_mode});  // entered
      wr(8'h00, 8'h00, 16);
      chk("locked", 8'h80, status_byte & 8'hFC);  // refused
   endtask
   initial begin
      clock = 1'b0;
      reset_n = 1'b0;
      wp_n_in = 1'b1;
      target_protected = 1'b0;
      pe_done = 1'b0;
      n_fail = 0;
      total_checks = 0;
      repeat (12) @(negedge clock);
      reset_n = 1'b1;
      repeat (4) @(negedge clock);
      t_reset();
      t_write();
      t_badlen();
      t_refuse();
      t_program();
      t_lock();
      report_and_stop();
   end
endmodule
